// file: hdl/dcs_pkg.sv
`default_nettype none
package dcs_pkg;
  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int CLK_MHZ = 100;
  localparam int STARTUP_US = 30;
  // deadline, so rounded down to whole cycles
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam logic [11:0] STARTUP_LAST = 12'(STARTUP_CYC - 1);
  localparam int WD_MS = 53;
  localparam int WD_CYC_DEF = WD_MS * 1000 * CLK_MHZ;
  localparam int WD_CNT_W = 23;

  // ****************************************************
  // frame layout, counted in serial clocks after select
  // ****************************************************
  localparam logic [6:0] BIT_CODE = 7'h08;   // control code complete
  localparam logic [6:0] BIT_RADDR = 7'h10;  // register address complete
  localparam logic [6:0] BIT_PROV = 7'h18;   // provisioning clocks complete
  localparam logic [6:0] BIT_RWR = 7'h20;    // register write data complete
  localparam logic [6:0] BIT_MAX = 7'h7F;
  localparam int PD_W = 32;
  localparam int TX_W = 64;
  localparam int BCAST_POS = 0;
  localparam int ADDR_LSB = 1;
  localparam int OP_LSB = 4;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [PD_W-1:0] PD_OUT_RST = 32'h0000_0000;
  localparam logic SDO_RST = 1'b0;

  typedef enum logic [3:0] {
    DCS_OP_NOP = 4'h0,
    DCS_OP_PD1 = 4'h1,
    DCS_OP_PD2 = 4'h2,
    DCS_OP_PD12 = 4'h3,
    DCS_OP_REG_RD = 4'h4,
    DCS_OP_REG_WR = 4'h5,
    DCS_OP_I2C_RD = 4'h6,
    DCS_OP_I2C_WR = 4'h7,
    DCS_OP_CH_STAT = 4'h8,
    DCS_OP_IRQ_FLAG = 4'h9,
    DCS_OP_SYNC1_RISE = 4'hA,
    DCS_OP_SYNC1_FALL = 4'hB,
    DCS_OP_SYNC2_RISE = 4'hC,
    DCS_OP_SYNC2_FALL = 4'hD,
    DCS_OP_I2C_STAT = 4'hE
  } dcs_op_e;

  // gray along wait -> load -> run; quick start branches off
  typedef enum logic [1:0] {
    DCS_ST_WAIT = 2'b00,
    DCS_ST_LOAD = 2'b01,
    DCS_ST_RUN = 2'b11,
    DCS_ST_QUICK = 2'b10
  } dcs_st_e;
endpackage
`default_nettype wire

// file: hdl/dcs_spi.sv
// How it works
// - sample serial input on clock falling edge, drive output on rising edge
// - input stream relayed to output half a serial clock later
// - first eight bits after select: opcode, chain address, broadcast bit
// - not addressed: stay idle and only relay; addressed: execute opcode
// - chain delay enable adds zero to seven clocks to output path
// - only the last device of up to eight enables the extra delay
// - extra delay count is derived from the own chain address
// - process data follows the control code on output without wait
// - register write data follows the address without padding
// - serial commands bridge to the I2C master for the EEPROM
// - sync opcodes pulse triggers chosen by edge and channel
// - short opcodes return channel status or interrupt flags directly
// - while not ready, all serial traffic is ignored
// - select low at the deadline means quick start without EEPROM load
// - quick start sets configuration and calibration CRC error bits
// - input process data latched on select falling edge
// - output process data applied on select rising edge
// - enabled watchdog resets after 53 ms without process-data transfer
// - ready stays low while configuration loads from the EEPROM
`default_nettype none
module dcs_spi
  import dcs_pkg::*;
#(
  parameter int WD_TIMEOUT_CYCLES = WD_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic external_reset_pin,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo,
  input wire logic [2:0] own_address,
  input wire logic chain_delay_enable,
  input wire logic watchdog_enable,
  input wire logic [PD_W-1:0] ch1_in_data,
  input wire logic [PD_W-1:0] ch2_in_data,
  output logic [PD_W-1:0] ch1_out_data,
  output logic [PD_W-1:0] ch2_out_data,
  output logic pd_apply,
  input wire logic [15:0] channel_status_register,
  input wire logic [15:0] irq_flag_register,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wr_data,
  output logic reg_wr_strobe,
  output logic reg_rd_strobe,
  input wire logic [15:0] reg_rd_data,
  output logic [7:0] i2c_mem_addr,
  output logic [7:0] i2c_wr_data,
  output logic i2c_wr_req,
  output logic i2c_rd_req,
  input wire logic i2c_busy,
  input wire logic [7:0] i2c_rd_data,
  output logic [3:0] sync_pulse,
  output logic eeprom_load_start,
  input wire logic eeprom_load_done,
  input wire logic conf_crc_bad,
  input wire logic calib_crc_bad,
  output logic ready,
  output logic conf_crc_err,
  output logic calib_crc_err,
  output logic wd_reset
);
  if (WD_TIMEOUT_CYCLES < 2 || WD_TIMEOUT_CYCLES >= 2 ** WD_CNT_W) begin : g_bad_wd
    $error("watchdog timeout does not fit its counter");
  end

  // ****************************************************
  // pin synchronisers and edge detection
  // ****************************************************
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic sdi_s1_reg, sdi_s2_reg;
  logic rst_pin_s1_reg, rst_pin_s2_reg;
  logic fall_evt, rise_evt, cs_fall_evt, cs_rise_evt;

  // two flops per pin; the third stage only serves edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h0;
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= 3'h7;
      {sdi_s1_reg, sdi_s2_reg} <= 2'h0;
      {rst_pin_s1_reg, rst_pin_s2_reg} <= 2'h0;
    end else begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {sclk, sclk_s1_reg, sclk_s2_reg};
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= {chip_select_n, cs_s1_reg, cs_s2_reg};
      {sdi_s1_reg, sdi_s2_reg} <= {sdi, sdi_s1_reg};
      {rst_pin_s1_reg, rst_pin_s2_reg} <= {external_reset_pin, rst_pin_s1_reg};
    end
  end

  assign fall_evt = sclk_s3_reg & ~sclk_s2_reg & ~cs_s2_reg;
  assign rise_evt = ~sclk_s3_reg & sclk_s2_reg & ~cs_s2_reg;
  assign cs_fall_evt = cs_s3_reg & ~cs_s2_reg;
  assign cs_rise_evt = ~cs_s3_reg & cs_s2_reg;

  // ****************************************************
  // startup, quick start and watchdog
  // ****************************************************
  dcs_st_e st_reg;
  logic [11:0] su_cnt_reg;
  logic [WD_CNT_W-1:0] wd_cnt_reg;
  logic wd_hit, pd_done;

  assign wd_hit = watchdog_enable && st_reg == DCS_ST_RUN && wd_cnt_reg == WD_CNT_W'(WD_TIMEOUT_CYCLES - 1);

  // reset pin low holds startup; its release starts the 30 us window
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= DCS_ST_WAIT;
      su_cnt_reg <= 12'h000;
      ready <= 1'b0;
      eeprom_load_start <= 1'b0;
      conf_crc_err <= 1'b0;
      calib_crc_err <= 1'b0;
    end else begin
      eeprom_load_start <= 1'b0;
      if (!rst_pin_s2_reg || wd_hit) begin
        st_reg <= DCS_ST_WAIT;
        su_cnt_reg <= 12'h000;
        ready <= 1'b0;
      end else begin
        case (st_reg)
          DCS_ST_WAIT: begin
            su_cnt_reg <= su_cnt_reg + 12'h001;
            if (su_cnt_reg == STARTUP_LAST) begin
              st_reg <= cs_s2_reg ? DCS_ST_LOAD : DCS_ST_QUICK;
              eeprom_load_start <= cs_s2_reg;
            end
          end
          DCS_ST_LOAD: begin
            if (eeprom_load_done) begin
              conf_crc_err <= conf_crc_bad;
              calib_crc_err <= calib_crc_bad;
              st_reg <= DCS_ST_RUN;
              ready <= 1'b1;
            end
          end
          DCS_ST_QUICK: begin
            conf_crc_err <= 1'b1;
            calib_crc_err <= 1'b1;
            st_reg <= DCS_ST_RUN;
            ready <= 1'b1;
          end
          DCS_ST_RUN: ready <= 1'b1;
          default: st_reg <= DCS_ST_WAIT;
        endcase
      end
    end
  end

  // watchdog restarted by each addressed process-data frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wd_cnt_reg <= '0;
      wd_reset <= 1'b0;
    end else begin
      wd_reset <= wd_hit;
      if (wd_hit || pd_done || !watchdog_enable || st_reg != DCS_ST_RUN) begin
        wd_cnt_reg <= '0;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
    end
  end

  // ****************************************************
  // frame decode and receive
  // ****************************************************
  logic [6:0] bit_cnt_reg;
  logic [TX_W-1:0] rx_reg, rx_next;
  logic [7:0] code_next;
  dcs_op_e op_reg;
  logic hit_reg, code_hit;
  logic is_pd;

  assign rx_next = {rx_reg[TX_W-2:0], sdi_s2_reg};
  assign code_next = rx_next[7:0];
  assign code_hit = code_next[BCAST_POS] || code_next[OP_LSB-1:ADDR_LSB] == own_address;
  assign is_pd = op_reg == DCS_OP_PD1 || op_reg == DCS_OP_PD2 || op_reg == DCS_OP_PD12;
  assign pd_done = cs_rise_evt && ready && hit_reg && is_pd;

  // nothing is counted while not ready
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt_reg <= 7'h00;
      rx_reg <= '0;
    end else if (!ready || cs_fall_evt) begin
      bit_cnt_reg <= 7'h00;
    end else if (fall_evt) begin
      rx_reg <= rx_next;
      if (bit_cnt_reg != BIT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 7'h01;
      end
    end
  end

  // control code taken on the eighth falling edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_reg <= DCS_OP_NOP;
      hit_reg <= 1'b0;
    end else if (!ready || cs_fall_evt) begin
      hit_reg <= 1'b0;
    end else if (fall_evt && bit_cnt_reg == BIT_CODE - 7'h01) begin
      op_reg <= dcs_op_e'(code_next[7:OP_LSB]);
      hit_reg <= code_hit;
    end
  end

  // ****************************************************
  // opcode actions
  // ****************************************************
  logic at_code, at_raddr, at_prov, at_rwr;

  assign at_code = fall_evt && bit_cnt_reg == BIT_CODE - 7'h01 && code_hit;
  assign at_raddr = fall_evt && hit_reg && bit_cnt_reg == BIT_RADDR - 7'h01;
  assign at_prov = fall_evt && hit_reg && bit_cnt_reg == BIT_PROV - 7'h01;
  assign at_rwr = fall_evt && hit_reg && bit_cnt_reg == BIT_RWR - 7'h01;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_addr <= 8'h00;
      reg_wr_data <= 16'h0000;
      reg_wr_strobe <= 1'b0;
      reg_rd_strobe <= 1'b0;
    end else begin
      reg_rd_strobe <= at_raddr && op_reg == DCS_OP_REG_RD;
      reg_wr_strobe <= at_rwr && op_reg == DCS_OP_REG_WR;
      if (at_raddr) begin
        reg_addr <= rx_next[7:0];
      end
      if (at_rwr) begin
        reg_wr_data <= rx_next[15:0];
      end
    end
  end

  // bridge to the I2C master; a request while busy is dropped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      i2c_mem_addr <= 8'h00;
      i2c_wr_data <= 8'h00;
      i2c_wr_req <= 1'b0;
      i2c_rd_req <= 1'b0;
    end else begin
      i2c_rd_req <= at_raddr && op_reg == DCS_OP_I2C_RD && !i2c_busy;
      i2c_wr_req <= at_prov && op_reg == DCS_OP_I2C_WR && !i2c_busy;
      if (at_raddr) begin
        i2c_mem_addr <= rx_next[7:0];
      end
      if (at_prov) begin
        i2c_wr_data <= rx_next[7:0];
      end
    end
  end

  // one-cycle sync trigger per edge and channel
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_pulse <= 4'h0;
    end else begin
      sync_pulse <= 4'h0;
      if (at_code && code_next[7:OP_LSB] >= DCS_OP_SYNC1_RISE && code_next[7:OP_LSB] <= DCS_OP_SYNC2_FALL) begin
        // opcodes A..D map in order onto bits 0..3
        sync_pulse <= 4'h1 << 2'(code_next[7:OP_LSB] - 4'hA);
      end
    end
  end

  // actuator values applied at the select rising edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ch1_out_data <= PD_OUT_RST;
      ch2_out_data <= PD_OUT_RST;
      pd_apply <= 1'b0;
    end else begin
      pd_apply <= pd_done;
      if (pd_done) begin
        case (op_reg)
          DCS_OP_PD1: ch1_out_data <= rx_reg[PD_W-1:0];
          DCS_OP_PD2: ch2_out_data <= rx_reg[PD_W-1:0];
          default: begin
            ch1_out_data <= rx_reg[TX_W-1:PD_W];
            ch2_out_data <= rx_reg[PD_W-1:0];
          end
        endcase
      end
    end
  end

  // ****************************************************
  // transmit and relay path
  // ****************************************************
  logic [TX_W-1:0] tx_reg;
  logic tx_on_reg;
  logic [7:0] dly_reg;
  logic [2:0] tap;
  logic out_bit;

  // sensor data latched at select falling edge; loaded after code
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_reg <= '0;
      tx_on_reg <= 1'b0;
    end else if (ready && cs_fall_evt) begin
      tx_reg <= {ch1_in_data, ch2_in_data};
      tx_on_reg <= 1'b0;
    end else if (at_code) begin
      tx_on_reg <= 1'b1;
      case (dcs_op_e'(code_next[7:OP_LSB]))
        DCS_OP_PD1, DCS_OP_PD12: tx_on_reg <= 1'b1;
        DCS_OP_PD2: tx_reg <= {tx_reg[PD_W-1:0], PD_OUT_RST};
        DCS_OP_CH_STAT: tx_reg <= {channel_status_register, 48'h0};
        DCS_OP_IRQ_FLAG: tx_reg <= {irq_flag_register, 48'h0};
        DCS_OP_I2C_STAT: tx_reg <= {i2c_busy, 7'h00, i2c_rd_data, 48'h0};
        default: tx_on_reg <= 1'b0;
      endcase
    end else if (at_prov && op_reg == DCS_OP_REG_RD) begin
      // read data follows the filler clocks
      tx_reg <= {reg_rd_data, 48'h0};
      tx_on_reg <= 1'b1;
    end else if (fall_evt && tx_on_reg) begin
      tx_reg <= {tx_reg[TX_W-2:0], 1'b0};
    end
  end

  // unaddressed or idle frames relay the input unchanged
  assign out_bit = tx_on_reg ? tx_reg[TX_W-1] : sdi_s2_reg;
  assign tap = chain_delay_enable ? 3'h7 - own_address : 3'h0;

  // delay line advances on falls; own data shares it so the chain stays aligned
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dly_reg <= 8'h00;
    end else if (fall_evt && ready) begin
      dly_reg <= {dly_reg[6:0], out_bit};
    end
  end

  // launch on the following rising edge, half a clock later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdo <= SDO_RST;
    end else if (rise_evt && ready) begin
      sdo <= dly_reg[tap];
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_ready_state: assert property (ready == (st_reg == DCS_ST_RUN))
    else $error("ready disagrees with startup state");
  chk_no_traffic_unready: assert property (!ready |=> bit_cnt_reg == 7'h00 && !hit_reg)
    else $error("serial traffic taken while not ready");
  chk_quick_sets_crc: assert property (st_reg == DCS_ST_QUICK |=> conf_crc_err && calib_crc_err && ready)
    else $error("quick start did not flag both crc errors");
  chk_deadline_quick: assert property (
    st_reg == DCS_ST_WAIT && su_cnt_reg == STARTUP_LAST && !cs_s2_reg && rst_pin_s2_reg
    |=> st_reg == DCS_ST_QUICK ##1 st_reg == DCS_ST_RUN)
    else $error("select low at deadline did not quick start");
  chk_relay_half_clk: assert property (
    rise_evt && ready && !chain_delay_enable |=> sdo == $past(dly_reg[0]))
    else $error("relay not half a clock behind");
  chk_apply_on_cs: assert property (pd_apply |-> $past(cs_rise_evt) && $past(hit_reg))
    else $error("outputs applied away from select rise");
  chk_latch_on_cs: assert property (
    cs_fall_evt && ready |=> tx_reg == {$past(ch1_in_data), $past(ch2_in_data)})
    else $error("inputs not latched at select fall");
  chk_sync_one_cycle: assert property ($onehot0(sync_pulse) and (sync_pulse != 4'h0 |=> sync_pulse == 4'h0))
    else $error("sync trigger malformed");
  chk_idle_unaddressed: assert property (reg_wr_strobe || i2c_wr_req |-> $past(hit_reg))
    else $error("unaddressed frame caused an action");
  chk_wd_expiry: assert property (wd_reset |-> $past(watchdog_enable) ##1 !ready)
    else $error("watchdog fired while disabled");

  cov_quick_start: cover property (st_reg == DCS_ST_QUICK);
  cov_pd_frame: cover property (pd_apply);
  cov_reg_read: cover property (reg_rd_strobe ##[1:300] cs_rise_evt);
  cov_i2c_write: cover property (i2c_wr_req);
endmodule
`default_nettype wire

// file: verif/dcs_host.sv
`default_nettype none
// ****************************************************
// serial host model, drives the frames at 125 ns a bit
// ****************************************************
module dcs_host (
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;

  // idle: clock stands high, select high
  initial begin
    sclk = 1'b1;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic hold_cs(input logic v);
    chip_select_n = v;
  endtask

  // exact length, no padding
  // the bench picks the length, so filler clocks are simply part of tx
  task automatic frame(input logic [95:0] tx, input int n, output logic [95:0] rx);
    rx = '0;
    chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = tx[n-1-i];
      #HALF;
      if (i > 0) rx[n-i] = sdo; // bit launched at the previous rise
      sclk = 1'b0;
      #HALF;
      sclk = 1'b1;
    end
    #HALF;
    rx[0] = sdo;
    chip_select_n = 1'b1;
    sdi = ~sdi; // released line shows no stale value
    #HALF;
  endtask
endmodule
`default_nettype wire

// file: verif/dcs_spi_test.sv
`default_nettype none
// ****************************************************
// self-checking bench for the chain slave port
// ****************************************************
module dcs_spi_test;
  import dcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst = 1'b1, external_reset_pin = 1'b1;
  wire logic sclk, chip_select_n, sdi;
  logic sdo, pd_apply, reg_wr_strobe, reg_rd_strobe, i2c_wr_req, i2c_rd_req, eeprom_load_start;
  logic ready, conf_crc_err, calib_crc_err, wd_reset;
  logic [2:0] own_address = 3'h2;
  logic chain_delay_enable = 1'b0, watchdog_enable = 1'b0, i2c_busy = 1'b0;
  logic eeprom_load_done = 1'b0, conf_crc_bad = 1'b0, calib_crc_bad = 1'b0;
  logic [PD_W-1:0] ch1_in_data = '0, ch2_in_data = '0, ch1_out_data, ch2_out_data;
  logic [15:0] channel_status_register = 16'hC31A, irq_flag_register = 16'h05E7;
  logic [15:0] reg_wr_data, reg_rd_data = 16'h9D2B;
  logic [7:0] reg_addr, i2c_mem_addr, i2c_wr_data, i2c_rd_data = 8'h6B;
  logic [3:0] sync_pulse;
  logic [10:0] seen = '0;
  logic seen_clr = 1'b0;
  logic [95:0] rx;
  int fail_count = 0, cmp_count = 0, cyc = 0;

  always #5 mclk = ~mclk;

  dcs_spi #(.WD_TIMEOUT_CYCLES(200)) i_dcs_spi (.mclk(mclk), .rst(rst), .external_reset_pin(external_reset_pin),
    .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo), .own_address(own_address),
    .chain_delay_enable(chain_delay_enable), .watchdog_enable(watchdog_enable), .ch1_in_data(ch1_in_data),
    .ch2_in_data(ch2_in_data), .ch1_out_data(ch1_out_data), .ch2_out_data(ch2_out_data), .pd_apply(pd_apply),
    .channel_status_register(channel_status_register), .irq_flag_register(irq_flag_register),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_strobe(reg_wr_strobe),
    .reg_rd_strobe(reg_rd_strobe), .reg_rd_data(reg_rd_data), .i2c_mem_addr(i2c_mem_addr),
    .i2c_wr_data(i2c_wr_data), .i2c_wr_req(i2c_wr_req), .i2c_rd_req(i2c_rd_req), .i2c_busy(i2c_busy),
    .i2c_rd_data(i2c_rd_data), .sync_pulse(sync_pulse), .eeprom_load_start(eeprom_load_start),
    .eeprom_load_done(eeprom_load_done), .conf_crc_bad(conf_crc_bad), .calib_crc_bad(calib_crc_bad),
    .ready(ready), .conf_crc_err(conf_crc_err), .calib_crc_err(calib_crc_err), .wd_reset(wd_reset));

  dcs_host i_dcs_host (.sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo));

  // pulses are one cycle wide, so collect them sticky until a test clears them
  always @(posedge mclk) begin
    seen <= seen_clr ? '0 : seen | {eeprom_load_start, wd_reset, pd_apply, reg_wr_strobe, reg_rd_strobe,
      i2c_wr_req, i2c_rd_req, sync_pulse};
  end

  // hang guard: all tests need well under this many cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
  end

  // wide enough for a whole 72-bit frame with its echoed code
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one frame with cleared pulse log, then let the select rise settle
  task automatic run(input logic [95:0] tx, input int n);
    @(negedge mclk);
    seen_clr = 1'b1;
    @(negedge mclk);
    seen_clr = 1'b0;
    i_dcs_host.frame(tx, n, rx);
    repeat (6) @(negedge mclk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic t_startup();
    for (int i = 0; i < 3100 && !seen[10]; i++) @(negedge mclk);
    check(seen[10], 1'b1);
    check(ready, 1'b0);
    run({8'h54, 8'h33, 16'hBEEF}, 32);
    check(seen[7], 1'b0);
    eeprom_load_done = 1'b1;
    @(negedge mclk);
    eeprom_load_done = 1'b0;
    repeat (3) @(negedge mclk);
    check({ready, conf_crc_err, calib_crc_err}, 3'b100);
    $display("test startup done");
  endtask

  task automatic t_process_data();
    ch1_in_data = 32'hA5C3_0F81;
    ch2_in_data = 32'h1234_5678;
    fork
      run({8'h34, 32'hCAFE_0001, 32'h8000_00FF}, 72);
      begin
        repeat (40) @(negedge mclk);
        ch1_in_data = 32'h0; // late change must not reach this frame
      end
    join
    check(rx[71:0], {8'h34, 32'hA5C3_0F81, 32'h1234_5678});
    check(ch1_out_data, 32'hCAFE_0001);
    check(ch2_out_data, 32'h8000_00FF);
    check(seen[8], 1'b1);
    run({8'h36, 64'h9E3B_71C4_0DF2_A856}, 72);
    check(rx[71:0], {8'h36, 64'h9E3B_71C4_0DF2_A856});
    check({ch1_out_data, seen[8]}, {32'hCAFE_0001, 1'b0});
    // last device at address 2 adds five clocks, so the echo lags by five bits
    chain_delay_enable = 1'b1;
    run({8'h36, 16'hA55A}, 24);
    check(rx[18:0], 19'h1B52A);
    check(rx[18:0], 19'h1B52A);
    chain_delay_enable = 1'b0;
    $display("test process data done");
  endtask

  task automatic t_registers();
    run({8'h54, 8'h3C, 16'hBEEF}, 32);
    check({reg_addr, reg_wr_data, seen[7]}, {8'h3C, 16'hBEEF, 1'b1});
    run({8'h44, 8'h7E, 8'hFF, 16'h0}, 40);
    check({reg_addr, seen[6]}, {8'h7E, 1'b1});
    check(rx[15:0], 16'h9D2B);
    run({8'h8B, 16'h0}, 24);
    check(rx[15:0], channel_status_register);
    run({8'h9B, 16'h0}, 24);
    check(rx[15:0], irq_flag_register);
    $display("test registers done");
  endtask

  task automatic t_sync_i2c();
    for (int op = 10; op < 14; op++) begin
      run({4'(op), 4'h4}, 8);
      check(seen[3:0], 4'h1 << (op - 10));
    end
    run({8'h74, 8'h12, 8'h5A}, 24);
    check({i2c_mem_addr, i2c_wr_data, seen[5]}, {8'h12, 8'h5A, 1'b1});
    run({8'h64, 8'h21}, 16);
    check({i2c_mem_addr, seen[4]}, {8'h21, 1'b1});
    run({8'hE4, 16'h0}, 24);
    check(rx[15:0], {8'h00, 8'h6B});
    // busy bridge: the poll shows busy and a new write is dropped
    i2c_busy = 1'b1;
    run({8'hE4, 16'h0}, 24);
    check(rx[15:0], {8'h80, 8'h6B});
    run({8'h74, 8'h13, 8'h77}, 24);
    check(seen[5], 1'b0);
    i2c_busy = 1'b0;
    $display("test sync and bridge done");
  endtask

  task automatic t_quick_start();
    i_dcs_host.hold_cs(1'b0);
    @(negedge mclk);
    external_reset_pin = 1'b0;
    repeat (5) @(negedge mclk);
    external_reset_pin = 1'b1;
    seen_clr = 1'b1;
    @(negedge mclk);
    seen_clr = 1'b0;
    repeat (3020) @(negedge mclk);
    check({ready, conf_crc_err, calib_crc_err}, 3'b111);
    check(seen[10], 1'b0);
    i_dcs_host.hold_cs(1'b1);
    $display("test quick start done");
  endtask

  // timeout is 200 cycles; a short process-data frame restarts it
  task automatic t_watchdog();
    watchdog_enable = 1'b1;
    repeat (60) @(negedge mclk);
    run({8'h14}, 8);
    check(seen[9], 1'b0);
    repeat (140) @(negedge mclk);
    check({seen[9], ready}, 2'b01);
    repeat (80) @(negedge mclk);
    check({seen[9], ready}, 2'b10);
    watchdog_enable = 1'b0;
    $display("test watchdog done");
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_startup();
    t_process_data();
    t_registers();
    t_sync_i2c();
    t_quick_start();
    t_watchdog();
    finish_test();
  end
endmodule
`default_nettype wire
